//--- logic/lvdic_pkg.sv
// constants shared by the low-voltage detector control logic
package lvdic_pkg;

   // register byte offsets, one aligned 32-bit word each
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] THRESH_OFFSET = 8'h04;
   localparam logic [7:0] IRQ_FLAG_OFFSET = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0c;

   // control register fields
   localparam int CTRL_LEVEL_BIT = 0;
   localparam int CTRL_ACTION_BIT = 1;
   localparam int CTRL_SOURCE_BIT = 2;
   localparam int CTRL_ENABLE_BIT = 7;

   // threshold field, bits 3 to 0
   localparam int THRESH_LSB = 0;
   localparam int THRESH_W = 4;

   // request flag and mask, bit 0 of their registers
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_MASK_BIT = 0;

   // reset values
   localparam logic CTRL_ENABLE_RESET = 1'b0;
   localparam logic CTRL_SOURCE_RESET = 1'b0;
   localparam logic CTRL_ACTION_RESET = 1'b0;
   localparam logic [3:0] THRESH_RESET = 4'h0;
   localparam logic IRQ_FLAG_RESET = 1'b0;
   localparam logic IRQ_MASK_RESET = 1'b1;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // timing: comparator stabilisation time, in clock cycles
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SETTLE_TIME_US = 10;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : lvdic_pkg

//--- logic/lvdic_det_if.sv
// carrier between the register side and the comparator front end
`timescale 1ns/1ps
`default_nettype none

interface lvdic_det_if;
   logic enable;
   logic source_sel;
   logic level;
   logic crossing;

   modport ctrl (output enable, output source_sel, input level, input crossing);
   modport det (input enable, input source_sel, output level, output crossing);
endinterface : lvdic_det_if

`default_nettype wire

//--- logic/lvdic_detector.sv
// comparator front end: synchronise, select source, settle, detect crossings
`timescale 1ns/1ps
`default_nettype none

module lvdic_detector #(
   parameter int SETTLE_CYCLES = lvdic_pkg::SETTLE_CYCLES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // comparator outputs, high while the voltage is below its threshold
   input wire logic i_supply_below,
   input wire logic i_sense_below,
   // register side
   lvdic_det_if.det det
);

   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);

   generate
      if (SETTLE_CYCLES < 1)
      begin : g_bad_settle
         $error("SETTLE_CYCLES must be at least 1");
      end
   endgenerate

   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic settled_reg;
   logic settled_next;
   logic prev_reg;
   logic prev_next;
   logic level_reg;
   logic level_next;
   logic cross_reg;
   logic cross_next;
   logic below;

   ////////////////////////////////////////////////////////////////////////////
   // pins are asynchronous, two flops before use
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
      end
      else
      begin
         meta_reg <= {i_sense_below, i_supply_below};
         sync_reg <= meta_reg;
      end
   end

   // sense pin compares against the fixed reference, supply against the field
   assign below = det.source_sel ? sync_reg[1] : sync_reg[0];

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      cnt_next = cnt_reg;
      settled_next = settled_reg;
      prev_next = below;
      level_next = below;
      cross_next = 1'b0;
      if (!det.enable)
      begin
         // idle detector: no events, flag held low
         cnt_next = '0;
         settled_next = 1'b0;
         level_next = 1'b0;
      end
      else if (!settled_reg)
      begin
         // no crossings are reported until the comparator has settled; the level flag already follows it
         cnt_next = cnt_reg + CNT_W'(1);
         if (cnt_reg == CNT_LAST)
         begin
            settled_next = 1'b1;
         end
      end
      else
      begin
         // either direction counts as an event
         cross_next = below != prev_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cnt_reg <= '0;
         settled_reg <= 1'b0;
         prev_reg <= 1'b0;
         level_reg <= 1'b0;
         cross_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         settled_reg <= settled_next;
         prev_reg <= prev_next;
         level_reg <= level_next;
         cross_reg <= cross_next;
      end
   end

   assign det.level = level_reg;
   assign det.crossing = cross_reg;

endmodule : lvdic_detector

`default_nettype wire

//--- logic/lvdic_ctrl.sv
// low-voltage detector control: axi4-lite registers, request flag, reset request
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - control bit 2 selects supply or sense pin
// - control bit 7 enables the detector
// - threshold field in bits 3..0, supply monitoring
// - control bit 0 reads live level flag
// - control bit 1 zero selects interrupt action
// - both crossing directions raise a request
// - request sets the interrupt request flag
// - request flag at bit 0, cleared by writing 0
// - reset sets the interrupt mask to one
// - writing 00h or clearing enable halts detection
// - sense pin uses fixed reference, not field
// - reset action holds reset while below threshold
module lvdic_ctrl #(
   parameter int ADDR_W = 4,
   parameter int SETTLE_CYCLES = lvdic_pkg::SETTLE_CYCLES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   // axi4-lite write response
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   // axi4-lite read data
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // comparator outputs, high while below threshold
   input wire logic i_supply_below,
   input wire logic i_sense_below,
   // comparator control
   output logic o_detector_enable,
   output logic o_source_select,
   output logic [3:0] o_threshold_select,
   // interrupt and internal reset request
   output logic o_detector_irq,
   output logic o_reset_req
);

   generate
      if (ADDR_W < 4)
      begin : g_bad_addr
         $error("ADDR_W must be at least 4");
      end
   endgenerate

   typedef enum {LVDIC_WR_IDLE, LVDIC_WR_RESP} lvdic_wr_t;
   typedef enum {LVDIC_RD_IDLE, LVDIC_RD_DATA} lvdic_rd_t;

   lvdic_det_if det ();

   // register state
   logic enable_reg;
   logic enable_next;
   logic source_reg;
   logic source_next;
   logic action_reg;
   logic action_next;
   logic [3:0] thresh_reg;
   logic [3:0] thresh_next;
   logic flag_reg;
   logic flag_next;
   logic mask_reg;
   logic mask_next;
   logic irq_reg;
   logic irq_next;
   logic rst_reg;
   logic rst_next;

   // bus state
   lvdic_wr_t wr_state_reg;
   lvdic_wr_t wr_state_next;
   lvdic_rd_t rd_state_reg;
   lvdic_rd_t rd_state_next;
   logic aw_held_reg;
   logic aw_held_next;
   logic w_held_reg;
   logic w_held_next;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [ADDR_W-1:0] aw_addr_next;
   logic [31:0] w_data_reg;
   logic [31:0] w_data_next;
   logic w_lane0_reg;
   logic w_lane0_next;
   logic awready_reg;
   logic awready_next;
   logic wready_reg;
   logic wready_next;
   logic bvalid_reg;
   logic bvalid_next;
   logic [1:0] bresp_reg;
   logic [1:0] bresp_next;
   logic arready_reg;
   logic arready_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0] rresp_reg;
   logic [1:0] rresp_next;

   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic do_write;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic [7:0] word_offset(input logic [ADDR_W-1:0] addr);
      logic [7:0] off;
      off = {4'h0, addr[3:2], 2'h0};
      return off;
   endfunction : word_offset

   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      logic upper_clear;
      upper_clear = (ADDR_W == 4) ? 1'b1 : (addr >> 4) == '0;
      return upper_clear;
   endfunction : is_mapped

   ////////////////////////////////////////////////////////////////////////////
   // comparator front end

   lvdic_detector #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_detector (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_supply_below(i_supply_below),
      .i_sense_below(i_sense_below),
      .det(det)
   );

   assign det.enable = enable_reg;
   assign det.source_sel = source_reg;

   ////////////////////////////////////////////////////////////////////////////
   // bus channels and register file

   assign aw_fire = i_s_axi_awvalid & awready_reg;
   assign w_fire = i_s_axi_wvalid & wready_reg;
   assign ar_fire = i_s_axi_arvalid & arready_reg;
   assign do_write = aw_held_reg & w_held_reg & (wr_state_reg == LVDIC_WR_IDLE);

   always_comb
   begin
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next = w_data_reg;
      w_lane0_next = w_lane0_reg;
      wr_state_next = wr_state_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rd_state_next = rd_state_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      enable_next = enable_reg;
      source_next = source_reg;
      action_next = action_reg;
      thresh_next = thresh_reg;
      flag_next = flag_reg;
      mask_next = mask_reg;

      // address and data are taken in either order
      if (aw_fire)
      begin
         aw_held_next = 1'b1;
         aw_addr_next = i_s_axi_awaddr;
      end
      if (w_fire)
      begin
         w_held_next = 1'b1;
         w_data_next = i_s_axi_wdata;
         w_lane0_next = i_s_axi_wstrb[0];
      end

      unique case (wr_state_reg)
         LVDIC_WR_IDLE:
         begin
            if (do_write)
            begin
               aw_held_next = 1'b0;
               w_held_next = 1'b0;
               wr_state_next = LVDIC_WR_RESP;
               bvalid_next = 1'b1;
               bresp_next = is_mapped(aw_addr_reg) ? lvdic_pkg::RESP_OKAY : lvdic_pkg::RESP_SLVERR;
            end
         end
         LVDIC_WR_RESP:
         begin
            if (i_s_axi_bready)
            begin
               wr_state_next = LVDIC_WR_IDLE;
               bvalid_next = 1'b0;
            end
         end
      endcase

      // all fields live in byte lane 0; other lanes are ignored
      if (do_write && w_lane0_reg && is_mapped(aw_addr_reg))
      begin
         unique case (word_offset(aw_addr_reg))
            lvdic_pkg::CTRL_OFFSET:
            begin
               // a 00h write clears enable and halts the detector
               enable_next = w_data_reg[lvdic_pkg::CTRL_ENABLE_BIT];
               source_next = w_data_reg[lvdic_pkg::CTRL_SOURCE_BIT];
               action_next = w_data_reg[lvdic_pkg::CTRL_ACTION_BIT];
            end
            lvdic_pkg::THRESH_OFFSET:
            begin
               thresh_next = w_data_reg[lvdic_pkg::THRESH_LSB +: lvdic_pkg::THRESH_W];
            end
            lvdic_pkg::IRQ_FLAG_OFFSET:
            begin
               // only a zero clears; a one leaves the flag alone
               if (!w_data_reg[lvdic_pkg::IRQ_FLAG_BIT])
               begin
                  flag_next = 1'b0;
               end
            end
            lvdic_pkg::IRQ_MASK_OFFSET:
            begin
               mask_next = w_data_reg[lvdic_pkg::IRQ_MASK_BIT];
            end
         endcase
      end

      unique case (rd_state_reg)
         LVDIC_RD_IDLE:
         begin
            if (ar_fire)
            begin
               rd_state_next = LVDIC_RD_DATA;
               rvalid_next = 1'b1;
               rdata_next = 32'h0;
               rresp_next = lvdic_pkg::RESP_OKAY;
               if (!is_mapped(i_s_axi_araddr))
               begin
                  rresp_next = lvdic_pkg::RESP_SLVERR;
               end
               else
               begin
                  unique case (word_offset(i_s_axi_araddr))
                     lvdic_pkg::CTRL_OFFSET:
                     begin
                        rdata_next[lvdic_pkg::CTRL_ENABLE_BIT] = enable_reg;
                        rdata_next[lvdic_pkg::CTRL_SOURCE_BIT] = source_reg;
                        rdata_next[lvdic_pkg::CTRL_ACTION_BIT] = action_reg;
                        rdata_next[lvdic_pkg::CTRL_LEVEL_BIT] = det.level;
                     end
                     lvdic_pkg::THRESH_OFFSET:
                     begin
                        rdata_next[lvdic_pkg::THRESH_LSB +: lvdic_pkg::THRESH_W] = thresh_reg;
                     end
                     lvdic_pkg::IRQ_FLAG_OFFSET:
                     begin
                        rdata_next[lvdic_pkg::IRQ_FLAG_BIT] = flag_reg;
                        flag_next = 1'b0;
                     end
                     lvdic_pkg::IRQ_MASK_OFFSET:
                     begin
                        rdata_next[lvdic_pkg::IRQ_MASK_BIT] = mask_reg;
                     end
                  endcase
               end
            end
         end
         LVDIC_RD_DATA:
         begin
            if (i_s_axi_rready)
            begin
               rd_state_next = LVDIC_RD_IDLE;
               rvalid_next = 1'b0;
            end
         end
      endcase

      // an event in the clearing cycle wins over the clear
      if (det.crossing && enable_reg && !action_reg)
      begin
         flag_next = 1'b1;
      end

      awready_next = !aw_held_next;
      wready_next = !w_held_next;
      arready_next = rd_state_next == LVDIC_RD_IDLE;

      irq_next = flag_next & ~mask_next;
      // reset action follows the level, not the crossing
      rst_next = enable_next & action_next & det.level;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         enable_reg <= lvdic_pkg::CTRL_ENABLE_RESET;
         source_reg <= lvdic_pkg::CTRL_SOURCE_RESET;
         action_reg <= lvdic_pkg::CTRL_ACTION_RESET;
         thresh_reg <= lvdic_pkg::THRESH_RESET;
         flag_reg <= lvdic_pkg::IRQ_FLAG_RESET;
         mask_reg <= lvdic_pkg::IRQ_MASK_RESET;
         irq_reg <= 1'b0;
         rst_reg <= 1'b0;
         wr_state_reg <= LVDIC_WR_IDLE;
         rd_state_reg <= LVDIC_RD_IDLE;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 32'h0;
         w_lane0_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= 2'h0;
      end
      else
      begin
         enable_reg <= enable_next;
         source_reg <= source_next;
         action_reg <= action_next;
         thresh_reg <= thresh_next;
         flag_reg <= flag_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
         rst_reg <= rst_next;
         wr_state_reg <= wr_state_next;
         rd_state_reg <= rd_state_next;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg <= w_data_next;
         w_lane0_reg <= w_lane0_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, each straight from a flop
   assign o_s_axi_awready = awready_reg;
   assign o_s_axi_wready = wready_reg;
   assign o_s_axi_bvalid = bvalid_reg;
   assign o_s_axi_bresp = bresp_reg;
   assign o_s_axi_arready = arready_reg;
   assign o_s_axi_rvalid = rvalid_reg;
   assign o_s_axi_rdata = rdata_reg;
   assign o_s_axi_rresp = rresp_reg;
   assign o_detector_enable = enable_reg;
   assign o_source_select = source_reg;
   assign o_threshold_select = thresh_reg;
   assign o_detector_irq = irq_reg;
   assign o_reset_req = rst_reg;

endmodule : lvdic_ctrl

`default_nettype wire

//--- bench/lvdic_ctrl_props.sv
// port-level checks for the detector control block
`timescale 1ns/1ps
`default_nettype none
module lvdic_ctrl_props (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // bus handshakes
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // detector side
   input wire logic o_detector_enable,
   input wire logic o_source_select,
   input wire logic [3:0] o_threshold_select,
   input wire logic o_reset_req
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////////////////////
   // control outputs only move when a write completes
   enable_follow_a: assert property ($changed(o_detector_enable) |-> $rose(o_s_axi_bvalid))
      else $error("enable output moved outside a write");
   source_follow_a: assert property ($changed(o_source_select) |-> $rose(o_s_axi_bvalid))
      else $error("source output moved outside a write");
   thresh_follow_a: assert property ($changed(o_threshold_select) |-> $rose(o_s_axi_bvalid))
      else $error("threshold output moved outside a write");
   // no reset request from a detector that was off
   reset_gate_a: assert property (o_reset_req |-> $past(o_detector_enable))
      else $error("reset request while detector disabled");
   ////////////////////////////////////////////////////////////////////////////
   write_resp_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
      |=> !o_s_axi_bvalid ##1 o_s_axi_bvalid)
      else $error("write response not two cycles after address and data");
   read_resp_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
      else $error("read data not one cycle after address");
   bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
      else $error("write response dropped before taken");
   rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
      else $error("read data dropped before taken");
endmodule : lvdic_ctrl_props

bind lvdic_ctrl lvdic_ctrl_props u_props (.i_clk, .i_reset_n, .i_s_axi_awvalid, .o_s_axi_awready,
   .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid,
   .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .o_detector_enable,
   .o_source_select, .o_threshold_select, .o_reset_req);
`default_nettype wire

//--- bench/low_voltage_detect_irq_ctrl_tb.sv
// self-checking bench for the low-voltage detector control block
`timescale 1ns/1ps
`default_nettype none
module low_voltage_detect_irq_ctrl_tb;
   // short settle count keeps the run brief
   localparam int ST = 4;
   logic i_clk, i_reset_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [4:0] i_s_axi_awaddr, i_s_axi_araddr;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
   logic [3:0] i_s_axi_wstrb, o_threshold_select;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
   logic i_supply_below, i_sense_below, o_detector_enable, o_source_select, o_detector_irq, o_reset_req;
   int n_fail = 0, cmp_count = 0, seed = 88541;
   int m_ctrl = 0, m_thr = 0, m_flag = 0, m_mask = 1, p_sup = 0, p_sen = 0;

   lvdic_ctrl #(.ADDR_W(5), .SETTLE_CYCLES(ST)) uut (.i_clk, .i_reset_n, .i_s_axi_awaddr,
      .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
      .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
      .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_supply_below, .i_sense_below,
      .o_detector_enable, .o_source_select, .o_threshold_select, .o_detector_irq, .o_reset_req);

   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // model level: disabled detector reads zero
   function automatic int lvl();
      return m_ctrl[7] ? (m_ctrl[2] ? p_sen : p_sup) : 0;
   endfunction : lvl

   task automatic do_reset;
      i_reset_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      m_ctrl = 0;
      m_thr = 0;
      m_flag = 0;
      m_mask = 1;
   endtask : do_reset

   // one bus transfer; ready to take the answer is held back at random
   task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q, output logic [1:0] r);
      int n;
      int dly;
      logic got;
      n = 0;
      got = 1'b0;
      dly = {$random(seed)} % 5;
      @(posedge i_clk);
      i_s_axi_awaddr <= a;
      i_s_axi_araddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_wstrb <= s;
      i_s_axi_awvalid <= wr;
      i_s_axi_wvalid <= wr;
      i_s_axi_arvalid <= !wr;
      while (!got && n < 100)
      begin
         @(posedge i_clk);
         n++;
         if (i_s_axi_awvalid && o_s_axi_awready)
            i_s_axi_awvalid <= 1'b0;
         if (i_s_axi_wvalid && o_s_axi_wready)
            i_s_axi_wvalid <= 1'b0;
         if (i_s_axi_arvalid && o_s_axi_arready)
            i_s_axi_arvalid <= 1'b0;
         got = wr ? (o_s_axi_bvalid && i_s_axi_bready) : (o_s_axi_rvalid && i_s_axi_rready);
         r = wr ? o_s_axi_bresp : o_s_axi_rresp;
         q = o_s_axi_rdata;
         i_s_axi_bready <= wr && !got && n >= dly;
         i_s_axi_rready <= !wr && !got && n >= dly;
      end
      // a transfer that never answers is a mismatch
      chk(got, 1'b1);
   endtask : xfer

   task automatic wchk(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] q;
      logic [1:0] r;
      int old;
      int en;
      old = lvl();
      en = m_ctrl[7];
      xfer(1'b1, a, d, s, q, r);
      chk(r, a > 5'd15 ? lvdic_pkg::RESP_SLVERR : lvdic_pkg::RESP_OKAY);
      if (a < 5'd16 && s[0])
         case (a)
            5'h00:
            begin
               m_ctrl = d & 32'h86;
               // swapping the source while running is a crossing too
               if (en && m_ctrl[7] && !m_ctrl[1] && lvl() != old)
                  m_flag = 1;
            end
            5'h04: m_thr = d & 32'hf;
            5'h08: m_flag = m_flag & d[0];
            default: m_mask = d[0];
         endcase
   endtask : wchk

   task automatic rchk(input logic [4:0] a);
      logic [31:0] q;
      logic [1:0] r;
      xfer(1'b0, a, 32'h0, 4'h0, q, r);
      chk(r, a > 5'd15 ? lvdic_pkg::RESP_SLVERR : lvdic_pkg::RESP_OKAY);
      case (a)
         5'h00: chk(q, m_ctrl | lvl());
         5'h04: chk(q, m_thr);
         5'h08: chk(q, m_flag);
         5'h0c: chk(q, m_mask);
         default: chk(q, 0);
      endcase
      // a read of the flag register also clears the flag
      if (a == 5'h08)
         m_flag = 0;
   endtask : rchk

   task automatic look;
      repeat (3) @(posedge i_clk);
      chk(o_detector_irq, m_flag & !m_mask);
      chk(o_detector_enable, m_ctrl[7]);
      chk(o_reset_req, m_ctrl[7] & m_ctrl[1] & lvl());
   endtask : look

   // drive the comparators and let the two-flop sync and flag register settle
   task automatic pin(input int sup, input int sen);
      int old;
      old = lvl();
      i_supply_below <= sup[0];
      i_sense_below <= sen[0];
      p_sup = sup;
      p_sen = sen;
      repeat (5) @(posedge i_clk);
      if (lvl() != old && !m_ctrl[1])
         m_flag = 1;
      look();
   endtask : pin

   task automatic on_wait(input logic [31:0] v);
      wchk(5'h00, v, 4'hf);
      repeat (ST + 8) @(posedge i_clk);
   endtask : on_wait
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_fail++;
      final_report();
   end

   initial
   begin
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid, i_s_axi_bready, i_s_axi_rready} <= '0;
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_wstrb} <= '0;
      {i_supply_below, i_sense_below} <= '0;
      do_reset();
      for (int a = 0; a < 20; a += 4)
         rchk(a[4:0]);
      wchk(5'h10, 32'hff, 4'hf);
      $display("test reset and unmapped done");
      repeat (4)
      begin
         wchk(5'h04, $random(seed), 4'hf);
         rchk(5'h04);
         chk(o_threshold_select, m_thr);
      end
      wchk(5'h04, 32'h5, 4'h0);
      rchk(5'h04);
      $display("test threshold done");
      on_wait(32'h80);
      rchk(5'h00);
      wchk(5'h08, 32'h0, 4'hf);
      wchk(5'h0c, 32'h0, 4'hf);
      pin(1, 0);
      rchk(5'h00);
      wchk(5'h08, 32'h1, 4'hf);
      look();
      wchk(5'h08, 32'h0, 4'hf);
      look();
      pin(0, 0);
      rchk(5'h08);
      look();
      wchk(5'h0c, 32'h1, 4'hf);
      pin(1, 0);
      rchk(5'h08);
      $display("test supply interrupt done");
      wchk(5'h00, 32'h0, 4'hf);
      on_wait(32'h84);
      chk(o_source_select, 1);
      pin(0, 0);
      wchk(5'h0c, 32'h0, 4'hf);
      pin(0, 1);
      rchk(5'h00);
      rchk(5'h08);
      $display("test sense pin done");
      for (int v = 0; v < 8; v += 4)
      begin
         on_wait(32'h80 | v);
         wchk(5'h00, v, 4'hf);
         pin(1, 0);
         pin(0, 1);
         rchk(5'h00);
         rchk(5'h08);
      end
      $display("test disable done");
      pin(0, 0);
      on_wait(32'h82);
      pin(1, 0);
      rchk(5'h08);
      pin(0, 0);
      pin(1, 0);
      wchk(5'h00, 32'h0, 4'hf);
      look();
      $display("test reset action done");
      wchk(5'h0c, 32'h0, 4'hf);
      do_reset();
      repeat (ST) @(posedge i_clk);
      rchk(5'h0c);
      rchk(5'h00);
      $display("test second reset done");
      final_report();
   end
endmodule : low_voltage_detect_irq_ctrl_tb
`default_nettype wire
